/* File: rtl/lrc_pkg.sv */
package lrc_pkg;
    // ***********************************************
    // widths of the compared output groups and the allowed core counts
    // ***********************************************
    localparam int CORE_OUT_W = 64;
    localparam int CCU_OUT_W = 64;
    localparam int SLV_OUT_W = 64;
    localparam int CORE_COUNT_ONE = 1;
    localparam int CORE_COUNT_TWO = 2;
    // reset level of the fault flag and mode synchroniser
    localparam logic FAULT_RESET = 1'b0;
    localparam logic MODE_RESET = 1'b0;

    // ***********************************************
    // operating modes of a two-core cluster
    // ***********************************************
    typedef enum logic {
        LRC_SPLIT,
        LRC_LOCKED
    } lrc_mode_t;
endpackage

/* File: rtl/lrc_compare.sv */
`timescale 1ns/100ps
// What this block does
// - compare core, coherency, slave port with copies
// - mismatch counts only while compare enabled
// - only primary copy drives pins and memories
// - redundant copy shares inputs, caches, memories
// - redundancy offered for one or two cores
// - mode input picks split or locked operation on a two-core build; one core is always locked
// - split mode: independent cores, own caches
// - locked mode: second core redundant, cache unused
module lrc_compare #(
    parameter int CORE_COUNT = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic compare_enable_in,
    input wire logic redundancy_mode_select,
    input wire logic [lrc_pkg::CORE_OUT_W-1:0] primaryCoreOut,
    input wire logic [lrc_pkg::CORE_OUT_W-1:0] redundantCoreOut,
    input wire logic [lrc_pkg::CCU_OUT_W-1:0] primaryCcuOut,
    input wire logic [lrc_pkg::CCU_OUT_W-1:0] redundantCcuOut,
    input wire logic [lrc_pkg::SLV_OUT_W-1:0] primarySlaveOut,
    input wire logic [lrc_pkg::SLV_OUT_W-1:0] redundantSlaveOut,
    input wire logic [lrc_pkg::CORE_OUT_W-1:0] secondCoreOut,
    output logic [lrc_pkg::CORE_OUT_W-1:0] pinOut,
    output logic [lrc_pkg::CORE_OUT_W-1:0] secondPinOut,
    output logic secondCacheEnable,
    output logic lockedMode,
    output logic compare_fault_out
);
    // ***********************************************
    // build-time check on the cluster size
    // ***********************************************
    // a three or four core build cannot carry a redundant copy
    if (CORE_COUNT != lrc_pkg::CORE_COUNT_ONE && CORE_COUNT != lrc_pkg::CORE_COUNT_TWO) begin : g_badCount
        $error("redundant lock-step needs a one or two core cluster");
    end

    localparam logic TWO_CORE = (CORE_COUNT == lrc_pkg::CORE_COUNT_TWO);

    // ***********************************************
    // mode latch
    // ***********************************************
    lrc_pkg::lrc_mode_t mode_reg;
    logic modeSync1_reg;
    logic modeSync2_reg;
    logic syncFill1_reg;
    logic syncFill2_reg;
    logic captured_reg;

    // the mode pin is a tie-off from outside, so resynchronise it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modeSync1_reg <= lrc_pkg::MODE_RESET;
            modeSync2_reg <= lrc_pkg::MODE_RESET;
        end else begin
            modeSync1_reg <= redundancy_mode_select;
            modeSync2_reg <= modeSync1_reg;
        end
    end

    // fill marker beside the synchroniser: stage two still shows its
    // reset value until two edges after release, so it must not be read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            syncFill1_reg <= 1'b0;
            syncFill2_reg <= 1'b0;
        end else begin
            syncFill1_reg <= 1'b1;
            syncFill2_reg <= syncFill1_reg;
        end
    end

    // caught once the synchroniser holds the pin; later pin changes are
    // ignored, so a stray toggle cannot flip a running cluster
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_reg <= lrc_pkg::LRC_LOCKED;
            captured_reg <= 1'b0;
        end else if (syncFill2_reg && !captured_reg) begin
            captured_reg <= 1'b1;
            if (!TWO_CORE || modeSync2_reg) begin
                mode_reg <= lrc_pkg::LRC_LOCKED;
            end else begin
                mode_reg <= lrc_pkg::LRC_SPLIT;
            end
        end
    end

    wire logic isLocked = (mode_reg == lrc_pkg::LRC_LOCKED);

    // ***********************************************
    // output steering: primary reaches pins, second core only in split mode
    // ***********************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinOut <= '0;
            secondPinOut <= '0;
            secondCacheEnable <= 1'b0;
            lockedMode <= 1'b1;
        end else begin
            pinOut <= primaryCoreOut;
            secondPinOut <= isLocked ? '0 : secondCoreOut;
            secondCacheEnable <= TWO_CORE && !isLocked;
            lockedMode <= isLocked;
        end
    end

    // ***********************************************
    // comparators
    // ***********************************************
    // one diff per group, all ORed into the single fault flag, which does not say which group failed
    wire logic coreDiff = (primaryCoreOut != redundantCoreOut);
    wire logic ccuDiff = (primaryCcuOut != redundantCcuOut);
    wire logic slaveDiff = (primarySlaveOut != redundantSlaveOut);
    wire logic mismatch = coreDiff || ccuDiff || slaveDiff;
    // in split mode the second core runs its own code, so no compare
    wire logic compareLive = compare_enable_in && isLocked && captured_reg;

    // same-clock inputs: sampled each cycle, fault registered next cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compare_fault_out <= lrc_pkg::FAULT_RESET;
        end else begin
            compare_fault_out <= compareLive && mismatch;
        end
    end

    // ***********************************************
    // checks
    // ***********************************************
    sequence s_diff;
        compareLive && mismatch;
    endsequence

    a_fault_on_mismatch: assert property (@(posedge clock) disable iff (rst)
        s_diff |=> compare_fault_out)
        else $error("mismatch did not raise fault");
    a_quiet_when_off: assert property (@(posedge clock) disable iff (rst)
        !compare_enable_in |=> !compare_fault_out)
        else $error("fault raised while compare disabled");
    a_fault_has_cause: assert property (@(posedge clock) disable iff (rst)
        compare_fault_out |-> $past(mismatch) && $past(compare_enable_in))
        else $error("fault without a prior mismatch");
    a_pin_follows_primary: assert property (@(posedge clock) disable iff (rst)
        !rst |=> pinOut == $past(primaryCoreOut))
        else $error("pin not driven from primary");
    a_mode_stable: assert property (@(posedge clock) disable iff (rst)
        captured_reg |=> $stable(mode_reg))
        else $error("mode changed out of reset");
    a_locked_cache_off: assert property (@(posedge clock) disable iff (rst)
        isLocked |=> !secondCacheEnable && secondPinOut == '0)
        else $error("second core used while locked");
    a_split_cache_on: assert property (@(posedge clock) disable iff (rst)
        !isLocked |=> secondCacheEnable)
        else $error("second cache off in split mode");

    // ***********************************************
    // checks on mode capture
    // ***********************************************
    // synchroniser full, capture not yet done
    sequence s_settled;
        syncFill2_reg && !captured_reg;
    endsequence

    a_mode_pick: assert property (@(posedge clock) disable iff (rst)
        s_settled ##0 TWO_CORE |=> isLocked == $past(modeSync2_reg))
        else $error("mode not taken from select input");
    // the capture waits for the fill marker and happens only once
    a_no_early_capture: assert property (@(posedge clock) disable iff (rst)
        !syncFill2_reg |=> !captured_reg)
        else $error("mode caught before synchroniser filled");
    a_capture_after_fill: assert property (@(posedge clock) disable iff (rst)
        $rose(captured_reg) |-> $past(syncFill2_reg))
        else $error("capture not preceded by a full synchroniser");
    a_capture_once: assert property (@(posedge clock) disable iff (rst)
        captured_reg |=> captured_reg)
        else $error("mode capture undone out of reset");
    a_single_locked: assert property (@(posedge clock) disable iff (rst)
        !TWO_CORE |-> isLocked)
        else $error("single core build left lock-step");
    a_lock_flag: assert property (@(posedge clock) disable iff (rst)
        !rst |=> lockedMode == $past(isLocked))
        else $error("locked flag does not follow mode");

    // ***********************************************
    // checks on the comparator path
    // ***********************************************
    // compare live and all three groups agree
    sequence s_clean;
        compareLive && !mismatch;
    endsequence

    // one fault cycle per mismatching cycle, none without a live compare
    a_fault_clears: assert property (@(posedge clock) disable iff (rst)
        s_clean |=> !compare_fault_out)
        else $error("fault held after groups agree");
    a_core_diff_caught: assert property (@(posedge clock) disable iff (rst)
        compareLive && coreDiff |=> compare_fault_out)
        else $error("core mismatch missed");
    a_ccu_diff_caught: assert property (@(posedge clock) disable iff (rst)
        compareLive && ccuDiff |=> compare_fault_out)
        else $error("coherency mismatch missed");
    a_slave_diff_caught: assert property (@(posedge clock) disable iff (rst)
        compareLive && slaveDiff |=> compare_fault_out)
        else $error("slave port mismatch missed");
    a_split_no_fault: assert property (@(posedge clock) disable iff (rst)
        !isLocked |=> !compare_fault_out)
        else $error("fault raised in split mode");
    a_precapture_quiet: assert property (@(posedge clock) disable iff (rst)
        !captured_reg |=> !compare_fault_out)
        else $error("fault raised before mode capture");
    a_fault_needs_lock: assert property (@(posedge clock) disable iff (rst)
        compare_fault_out |-> $past(isLocked) && $past(captured_reg))
        else $error("fault raised outside locked mode");

    // ***********************************************
    // checks on the second core in split mode
    // ***********************************************
    // split-mode data path, one register stage
    a_second_pin_split: assert property (@(posedge clock) disable iff (rst)
        !rst && !isLocked |=> secondPinOut == $past(secondCoreOut))
        else $error("second core pins not driven in split mode");
endmodule

/* File: test/lrc_safety_model.sv */
`timescale 1ns/100ps
// safety logic: enables compare after init, mode fixed out of reset
module lrc_safety_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic initDone,
    input wire logic modeReq,
    output logic compare_enable_in,
    output logic redundancy_mode_select
);
    // enable only after init; registered to keep it glitch free
    always_ff @(posedge clock or posedge rst) begin
        if (rst) compare_enable_in <= 1'b0;
        else compare_enable_in <= initDone;
    end
    // mode follows request only while reset is held
    always_ff @(posedge clock) begin
        if (rst) redundancy_mode_select <= modeReq;
    end
endmodule

/* File: test/lockstep_redundancy_compare_tb.sv */
`timescale 1ns/100ps
module lockstep_redundancy_compare_tb;
    logic clock, rst, initDone, modeReq, en, mode, f1, f2, lk1, lk2, sce1, sce2;
    logic [63:0] pc, rc, pu, ru, ps, rs, sc, pin1, pin2, sp1, sp2;
    int err_count, checks;
    lrc_safety_model u_lrc_safety_model (.clock(clock), .rst(rst), .initDone(initDone), .modeReq(modeReq),
        .compare_enable_in(en), .redundancy_mode_select(mode));
    // single core is forced locked; two-core follows the mode pin
    lrc_compare #(.CORE_COUNT(1)) u_lrc_compare (.clock(clock), .rst(rst), .compare_enable_in(en),
        .redundancy_mode_select(mode), .primaryCoreOut(pc), .redundantCoreOut(rc), .primaryCcuOut(pu),
        .redundantCcuOut(ru), .primarySlaveOut(ps), .redundantSlaveOut(rs), .secondCoreOut(sc), .pinOut(pin1),
        .secondPinOut(sp1), .secondCacheEnable(sce1), .lockedMode(lk1), .compare_fault_out(f1));
    lrc_compare #(.CORE_COUNT(2)) u_lrc_compare_dual (.clock(clock), .rst(rst), .compare_enable_in(en),
        .redundancy_mode_select(mode), .primaryCoreOut(pc), .redundantCoreOut(rc), .primaryCcuOut(pu),
        .redundantCcuOut(ru), .primarySlaveOut(ps), .redundantSlaveOut(rs), .secondCoreOut(sc), .pinOut(pin2),
        .secondPinOut(sp2), .secondCacheEnable(sce2), .lockedMode(lk2), .compare_fault_out(f2));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one mismatch per pair, fault lasts exactly one cycle
    task t_fault(input logic expDual);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            rc <= (i == 0) ? ~pc : pc;
            ru <= (i == 1) ? ~pu : pu;
            rs <= (i == 2) ? ~ps : ps;
            @(posedge clock);
            {rc, ru, rs} <= {pc, pu, ps};
            #1 chk(f1, 1'b1);
            chk(f2, expDual);
            chk(pin1, pc);
            chk(pin2, pc);
            @(posedge clock);
            #1 chk(f1, 1'b0);
            chk(f2, 1'b0);
        end
    endtask
    // mismatch with compare disabled must leave no trace
    task t_off;
        @(posedge clock) initDone <= 1'b0;
        repeat (3) @(posedge clock);
        rc <= ~pc;
        repeat (2) @(posedge clock);
        #1 chk(f1, 1'b0);
        chk(f2, 1'b0);
        @(posedge clock) rc <= pc;
        initDone <= 1'b1;
        repeat (3) @(posedge clock);
    endtask
    // second core: own pins and cache in split, silent while locked
    task t_mode(input logic lockReq);
        @(posedge clock) sc <= 64'hA5A5_0F0F_1234_5678;
        @(posedge clock);
        #1 chk({lk1, lk2, sce2, sce1}, {1'b1, lockReq, !lockReq, 1'b0});
        chk(sp2, lockReq ? 64'h0 : sc);
        chk(sp1, 64'h0);
    endtask
    // reset with a chosen mode; mode is taken once the synchroniser is full
    task t_reset(input logic lockReq);
        @(posedge clock);
        rst <= 1'b1;
        initDone <= 1'b0;
        modeReq <= lockReq;
        repeat (2) @(posedge clock);
        #1 chk({f1, f2, lk1, lk2, sce1, sce2}, 6'h0C);
        chk(pin2, 64'h0);
        chk(sp2, 64'h0);
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1 chk({f1, f2, lk2}, 3'h1);
        chk(pin1, pc);
        @(posedge clock);
        #1 chk({f1, f2, lk2, sce2}, 4'h2);
        repeat (2) @(posedge clock);
        #1 chk({lk2, sce2, lk1, sce1}, {lockReq, !lockReq, 2'h2});
        @(posedge clock);
        initDone <= 1'b1;
        repeat (2) @(posedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #100000 err_count++;
        stop_test;
    end
    // ***************
    // main sequence
    // ***************
    initial begin
        {rst, initDone, modeReq} = 3'h4;
        {pc, pu, ps, sc} = {64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3210, 64'h0F0F_F0F0_3C3C_C3C3, 64'h0};
        {rc, ru, rs} = {pc, pu, ps};
        t_reset(1'b0);
        t_fault(1'b0);
        t_off;
        t_mode(1'b0);
        t_reset(1'b1);
        t_mode(1'b1);
        t_fault(1'b1);
        t_off;
        t_fault(1'b1);
        stop_test;
    end
endmodule
